// *** rtl/fpsi_consts.svh ***
// Constants for the front-panel status indicator block.
//
// Overview of operation
// - Host traffic flashes the activity lamp green.
// - Command error or overrun lights fault lamp.
// - Fault lamp is OR of three event flags.
// - Only reset, the clear command or a W1C write to event status extinguishes the fault lamp.
// - Slow output beyond 8 V lights saturation lamp.
// - Saturation lamp follows high/low flags live.
// - Slow integrator limit also lights saturation lamp.
// - Host selects signal copied to diagnostic output.
// - Acquisition input may trigger control state machine.
`ifndef FPSI_CONSTS_SVH
`define FPSI_CONSTS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define FPSI_ADDR_EVENT_STATUS 12'h000
`define FPSI_ADDR_OVERLOAD 12'h004
`define FPSI_ADDR_MONITOR_SEL 12'h008
`define FPSI_ADDR_ACQ_CTRL 12'h00C
`define FPSI_ADDR_LAMPS 12'h010

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FPSI_BIT_RXQ_OVF 0
`define FPSI_BIT_RUN_FAULT 1
`define FPSI_BIT_CMD_SYNTAX 2
`define FPSI_BIT_SEC_HIGH 0
`define FPSI_BIT_SEC_LOW 1
`define FPSI_BIT_SEC_INTEG 2
`define FPSI_BIT_ACQ_EN 0
`define FPSI_BIT_ACQ_LEVEL 1
`define FPSI_MON_SEL_W 4
`define FPSI_MON_SRC_N 16

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define FPSI_RST_MON_SEL 4'h0
`define FPSI_RST_ACQ_CTRL 2'h0
`define FPSI_CLK_HZ 40000000
`define FPSI_FLASH_MS 50
`define FPSI_FLASH_CYCLES ((`FPSI_CLK_HZ / 1000) * `FPSI_FLASH_MS)
`define FPSI_FLASH_W 21

`endif

// *** rtl/fpsi_pkg.sv ***
// Types for the front-panel status indicator block.
`include "fpsi_consts.svh"

package fpsi_pkg;

    typedef struct packed {
        logic rx_byte;
        logic tx_byte;
        logic receive_queue_overflow;
        logic run_fault;
        logic command_syntax_fault;
    } fpsi_host_ev_t;

    typedef struct packed {
        logic secondary_output_high;
        logic secondary_output_low;
        logic secondary_integrator_limit;
    } fpsi_ovl_t;

    typedef struct packed {
        logic host_link_activity_lamp;
        logic host_fault_lamp;
        logic secondary_output_saturation_lamp;
    } fpsi_lamps_t;

    typedef enum logic [2:0] {
        FPSI_ACQ_IDLE = 3'b001,
        FPSI_ACQ_HIGH = 3'b010,
        FPSI_ACQ_WAIT = 3'b100
    } fpsi_acq_state_t;

endpackage

// *** rtl/fpsi_top.sv ***
// Front-panel indicator logic with an APB register slave.
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
`include "fpsi_consts.svh"

module fpsi_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire fpsi_pkg::fpsi_host_ev_t host_ev,
    input wire logic clear_status_command,
    input wire fpsi_pkg::fpsi_ovl_t ovl_pin,
    input wire logic [`FPSI_MON_SRC_N-1:0] monitor_sources,
    input wire logic acquisition_input,
    output logic diagnostic_output,
    output logic acquisition_event,
    output fpsi_pkg::fpsi_lamps_t lamps
);

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    fpsi_pkg::fpsi_ovl_t ovl_meta;
    fpsi_pkg::fpsi_ovl_t ovl_sync;
    logic acq_meta;
    logic acq_sync;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovl_meta <= '0;
            ovl_sync <= '0;
            acq_meta <= 1'b0;
            acq_sync <= 1'b0;
        end else begin
            ovl_meta <= ovl_pin;
            ovl_sync <= ovl_meta;
            acq_meta <= acquisition_input;
            acq_sync <= acq_meta;
        end
    end

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    wire apb_access = psel && penable;
    wire apb_write = apb_access && pwrite;
    wire hit_event_status_register = (paddr == `FPSI_ADDR_EVENT_STATUS);
    wire hit_ovl = (paddr == `FPSI_ADDR_OVERLOAD);
    wire hit_mon = (paddr == `FPSI_ADDR_MONITOR_SEL);
    wire hit_acq = (paddr == `FPSI_ADDR_ACQ_CTRL);
    wire hit_lamp = (paddr == `FPSI_ADDR_LAMPS);
    wire hit_any = hit_event_status_register || hit_ovl || hit_mon || hit_acq || hit_lamp;

    assign pready = 1'b1;
    assign pslverr = apb_access && !hit_any;

    // ----------------------------------------
    // Event status register
    // ----------------------------------------
    logic [2:0] event_status_register;
    wire [2:0] ev_set = {host_ev.command_syntax_fault, host_ev.run_fault,
        host_ev.receive_queue_overflow};
    wire [2:0] ev_clr_w1c = (apb_write && hit_event_status_register) ? pwdata[2:0] : 3'h0;
    wire [2:0] ev_clr = clear_status_command ? 3'h7 : ev_clr_w1c;
    wire [2:0] next_event_status = (event_status_register & ~ev_clr) | ev_set;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_status_register <= 3'h0;
        end else begin
            event_status_register <= next_event_status;
        end
    end

    // ----------------------------------------
    // Monitor select and acquisition control
    // ----------------------------------------
    logic [`FPSI_MON_SEL_W-1:0] monitor_select;
    logic [1:0] acq_ctrl;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            monitor_select <= `FPSI_RST_MON_SEL;
            acq_ctrl <= `FPSI_RST_ACQ_CTRL;
        end else begin
            if (apb_write && hit_mon) begin
                monitor_select <= pwdata[`FPSI_MON_SEL_W-1:0];
            end
            if (apb_write && hit_acq) begin
                acq_ctrl <= pwdata[1:0];
            end
        end
    end

    wire next_diag = monitor_sources[monitor_select];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            diagnostic_output <= 1'b0;
        end else begin
            diagnostic_output <= next_diag;
        end
    end

    // ----------------------------------------
    // Acquisition event state machine
    // ----------------------------------------
    fpsi_pkg::fpsi_acq_state_t acq_state;
    fpsi_pkg::fpsi_acq_state_t next_acq_state;
    wire acq_en = acq_ctrl[`FPSI_BIT_ACQ_EN];
    wire acq_active = acq_ctrl[`FPSI_BIT_ACQ_LEVEL] ? !acq_sync : acq_sync;
    logic next_acq_event;

    always_comb begin
        next_acq_state = acq_state;
        next_acq_event = 1'b0;
        case (acq_state)
            fpsi_pkg::FPSI_ACQ_IDLE: begin
                if (acq_en && acq_active) begin
                    next_acq_state = fpsi_pkg::FPSI_ACQ_HIGH;
                    next_acq_event = 1'b1;
                end
            end
            fpsi_pkg::FPSI_ACQ_HIGH: begin
                next_acq_state = fpsi_pkg::FPSI_ACQ_WAIT;
            end
            fpsi_pkg::FPSI_ACQ_WAIT: begin
                if (!acq_active || !acq_en) begin
                    next_acq_state = fpsi_pkg::FPSI_ACQ_IDLE;
                end
            end
            default: begin
                next_acq_state = fpsi_pkg::FPSI_ACQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acq_state <= fpsi_pkg::FPSI_ACQ_IDLE;
            acquisition_event <= 1'b0;
        end else begin
            acq_state <= next_acq_state;
            acquisition_event <= next_acq_event;
        end
    end

    // ----------------------------------------
    // Activity flash stretcher
    // ----------------------------------------
    localparam logic [`FPSI_FLASH_W-1:0] FLASH_LOAD =
        `FPSI_FLASH_W'(`FPSI_FLASH_CYCLES);
    logic [`FPSI_FLASH_W-1:0] flash_count;
    wire traffic = host_ev.rx_byte || host_ev.tx_byte;
    wire [`FPSI_FLASH_W-1:0] next_flash_count = traffic ? FLASH_LOAD :
        (flash_count != '0) ? flash_count - 1'b1 : flash_count;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_count <= '0;
        end else begin
            flash_count <= next_flash_count;
        end
    end

    // ----------------------------------------
    // Lamp drivers
    // ----------------------------------------
    fpsi_pkg::fpsi_lamps_t next_lamps;
    assign next_lamps.host_fault_lamp = |next_event_status;
    assign next_lamps.host_link_activity_lamp = (next_flash_count != '0);
    assign next_lamps.secondary_output_saturation_lamp =
        ovl_sync.secondary_output_high || ovl_sync.secondary_output_low ||
        ovl_sync.secondary_integrator_limit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lamps <= '0;
        end else begin
            lamps <= next_lamps;
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    wire [31:0] rd_event_status_register = {29'h0, event_status_register};
    wire [31:0] rd_ovl = {29'h0, ovl_sync.secondary_integrator_limit,
        ovl_sync.secondary_output_low, ovl_sync.secondary_output_high};
    wire [31:0] rd_mon = {28'h0, monitor_select};
    wire [31:0] rd_acq = {30'h0, acq_ctrl};
    wire [31:0] rd_lamp = {29'h0, lamps};
    wire [31:0] next_prdata = hit_event_status_register ? rd_event_status_register : hit_ovl ? rd_ovl :
        hit_mon ? rd_mon : hit_acq ? rd_acq : hit_lamp ? rd_lamp : 32'h0;

    assign prdata = (psel && !pwrite) ? next_prdata : 32'h0;

endmodule

// *** testbench/fpsi_analog_src.sv ***
// Model of the slow-path overload and acquisition level sources.
`timescale 1ns/1ps
module fpsi_analog_src (
    input wire logic [2:0] want,
    input wire logic acq_want,
    output fpsi_pkg::fpsi_ovl_t ovl_pin,
    output logic acquisition_input
);
    assign ovl_pin = want;
    assign acquisition_input = acq_want;
endmodule

// *** testbench/fpsi_chk.sv ***
// Assertions on the indicator block's ports.
`timescale 1ns/1ps
module fpsi_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic pwrite,
    input wire fpsi_pkg::fpsi_host_ev_t host_ev,
    input wire logic clear_status_command,
    input wire fpsi_pkg::fpsi_ovl_t ovl_pin,
    input wire logic acquisition_event,
    input wire fpsi_pkg::fpsi_lamps_t lamps
);
    wire flt = |host_ev[2:0];
    wire act = lamps.host_link_activity_lamp;
    wire fl = lamps.host_fault_lamp;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_lit8;
        act [*8];
    endsequence
    a_fault_set: assert property (flt |=> fl)
        else $error("Fault lamp not lit.");
    a_fault_hold: assert property (
        fl && !clear_status_command && !(psel && pwrite) |=> fl)
        else $error("Fault lamp cleared itself.");
    a_fault_clear: assert property (
        clear_status_command && !flt |=> !fl)
        else $error("Fault lamp not cleared.");
    a_fault_quiet: assert property (!fl && !flt |=> !fl)
        else $error("Fault lamp lit without cause.");
    a_act_flash: assert property (
        host_ev.rx_byte || host_ev.tx_byte |=> act)
        else $error("Activity lamp not lit.");
    a_act_stretch: assert property ($rose(act) |-> s_lit8)
        else $error("Activity flash too short.");
    a_sat_follow: assert property (
        $past(presetn, 3) |->
        lamps.secondary_output_saturation_lamp == $past(|ovl_pin, 3))
        else $error("Saturation lamp not following flags.");
    a_acq_pulse: assert property (
        acquisition_event |=> !acquisition_event)
        else $error("Acquisition event too long.");
endmodule
bind fpsi_top fpsi_chk i_fpsi_chk (.*);

// *** testbench/fpsi_tb_top.sv ***
// Self-checking bench for the indicator block.
`timescale 1ns/1ps
module fpsi_tb_top;
    logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [15:0] monitor_sources = '0;
    logic [2:0] want = '0;
    logic pready, pslverr, err, ok, diagnostic_output, acquisition_event;
    logic clear_status_command = '0, acq_want = '0, acquisition_input;
    fpsi_pkg::fpsi_host_ev_t host_ev = '0;
    fpsi_pkg::fpsi_ovl_t ovl_pin;
    fpsi_pkg::fpsi_lamps_t lamps;
    int n_mismatch = 0, total_checks = 0, n;
    always #12.5 pclk = ~pclk;
    fpsi_top i_fpsi_top (.*);
    fpsi_analog_src i_fpsi_analog_src (.*);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(negedge pclk);
            rd = prdata;
            err = pslverr;
            ok = pready;
            @(posedge pclk);
        end while (ok !== 1'h1);
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task automatic sc_fault();
        for (int k = 0; k < 3; k++) begin
            host_ev <= 5'(1 << k);
            @(posedge pclk);
            host_ev <= '0;
            repeat (3) @(posedge pclk);
            chk(lamps.host_fault_lamp, 1'h1);
            apb(1'h0, 12'h000, 32'h0);
            chk(rd, 32'h4 >> k);
            chk(lamps.host_fault_lamp, 1'h1);
            if (k == 0) begin
                clear_status_command <= 1'h1;
                @(posedge pclk);
                clear_status_command <= 1'h0;
            end else begin
                apb(1'h1, 12'h000, 32'h4 >> k);
            end
            @(posedge pclk);
            chk(lamps.host_fault_lamp, 1'h0);
        end
    endtask
    task automatic sc_act();
        host_ev <= 5'h10;
        @(posedge pclk);
        host_ev <= 5'h08;
        @(posedge pclk);
        host_ev <= '0;
        repeat (20) @(posedge pclk);
        chk(lamps.host_link_activity_lamp, 1'h1);
        apb(1'h0, 12'h010, 32'h0);
        chk(rd[2], 1'h1);
    endtask
    task automatic sc_sat();
        for (int k = 0; k < 3; k++) begin
            want <= 3'(1 << k);
            repeat (5) @(posedge pclk);
            chk(lamps.secondary_output_saturation_lamp, 1'h1);
            apb(1'h0, 12'h004, 32'h0);
            chk(rd, 32'h4 >> k);
            want <= '0;
            repeat (5) @(posedge pclk);
            chk(lamps.secondary_output_saturation_lamp, 1'h0);
        end
    endtask
    task automatic sc_diag();
        monitor_sources <= 16'hA5C3;
        for (int k = 0; k < 16; k++) begin
            apb(1'h1, 12'h008, k);
            @(posedge pclk);
            chk(diagnostic_output, 32'(16'hA5C3 >> k) & 32'h1);
        end
    endtask
    task automatic sc_acq();
        apb(1'h1, 12'h00C, 32'h1);
        acq_want <= 1'h1;
        n = 0;
        repeat (12) begin
            @(posedge pclk);
            if (acquisition_event === 1'h1) n++;
        end
        chk(n, 32'h1);
        acq_want <= 1'h0;
        repeat (4) @(posedge pclk);
        apb(1'h1, 12'h00C, 32'h3);
        n = 0;
        repeat (12) begin
            @(posedge pclk);
            if (acquisition_event === 1'h1) n++;
        end
        chk(n, 32'h1);
        apb(1'h1, 12'h00C, 32'h0);
        apb(1'h1, 12'h020, 32'hFFFFFFFF);
        chk(err, 1'h1);
        apb(1'h0, 12'h020, 32'h0);
        chk(rd, 32'h0);
    endtask
    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        chk(lamps, 32'h0);
        sc_fault();
        sc_act();
        sc_sat();
        sc_diag();
        sc_acq();
        wrap_up();
    end
    initial begin
        #(25 * 5000);
        n_mismatch++;
        wrap_up();
    end
endmodule
